/* bench/remc_ctrl_monitor.sv */
// concurrent checks on the mode-pin controller ports
`timescale 1ns/10ps
module remc_ctrl_monitor (
   // clock and reset
   input wire logic                  clk_sys,
   input wire logic                  srst,
   // device pins
   input wire remc_pkg::remc_level_t chip_sel_lvl,
   input wire remc_pkg::remc_level_t out_en_lvl,
   input wire remc_pkg::remc_level_t strobe_lvl,
   input wire logic                  vpp_high,
   input wire logic [13:0]           byte_addr_lines,
   input wire logic                  data_bus_lines_oe
);
   localparam remc_pkg::remc_level_t LO = remc_pkg::REMC_LVL_LOW;
   localparam remc_pkg::remc_level_t HI = remc_pkg::REMC_LVL_HIGH;
   localparam remc_pkg::remc_level_t SH = remc_pkg::REMC_LVL_SUPER;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   no_dual_super_a: assert property (!(chip_sel_lvl == SH
      && out_en_lvl == SH))
      else $error("select and enable both at super level");
   read_pins_a: assert property (out_en_lvl == LO
      |-> chip_sel_lvl == LO)
      else $error("output enable low without chip select low");
   repl_addr_a: assert property (chip_sel_lvl == SH
      |-> byte_addr_lines[7:0] == 8'h00)
      else $error("replace with nonzero low address byte");
   pulse_vpp_a: assert property (strobe_lvl != HI |-> vpp_high)
      else $error("strobe pulse without programming supply");
   erase_pins_a: assert property (out_en_lvl == SH
      |-> chip_sel_lvl == LO)
      else $error("bulk erase without chip select low");
   repl_pins_a: assert property (chip_sel_lvl == SH |-> out_en_lvl == HI)
      else $error("replace without output enable high");
   erepl_pins_a: assert property (strobe_lvl == SH |->
      chip_sel_lvl == HI && out_en_lvl == HI)
      else $error("erase of spare with wrong select levels");
   bus_fight_a: assert property (data_bus_lines_oe |-> out_en_lvl != LO)
      else $error("controller drives while device may drive");
   hold_stable_a: assert property (strobe_lvl != HI && $past(strobe_lvl) != HI
      |-> $stable(byte_addr_lines) && $stable(chip_sel_lvl))
      else $error("pins moved during strobe pulse");
   pulse_len_a: assert property ($rose(strobe_lvl == LO) |->
      (strobe_lvl == LO) [*8])
      else $error("strobe pulse too short");
   reset_idle_a: assert property (disable iff (1'b0) srst |=>
      chip_sel_lvl == HI && out_en_lvl == HI && !vpp_high)
      else $error("pins not idle after reset");
endmodule
bind remc_ctrl remc_ctrl_monitor remc_ctrl_monitor_inst (.clk_sys(clk_sys),
   .srst(srst), .chip_sel_lvl(chip_sel_lvl), .out_en_lvl(out_en_lvl),
   .strobe_lvl(strobe_lvl), .vpp_high(vpp_high),
   .byte_addr_lines(byte_addr_lines), .data_bus_lines_oe(data_bus_lines_oe));

/* bench/remc_dev_model.sv */
// behavioural rom/eeprom device with one spare page
`timescale 1ns/10ps
module remc_dev_model (
   // clock
   input wire logic                  clk_sys,
   // device pins
   input wire remc_pkg::remc_level_t chip_sel_lvl,
   input wire remc_pkg::remc_level_t out_en_lvl,
   input wire remc_pkg::remc_level_t strobe_lvl,
   input wire logic                  vpp_high,
   input wire logic [13:0]           byte_addr_lines,
   input wire logic [7:0]            data_bus_lines_out,
   input wire logic                  data_bus_lines_oe,
   // resolved bus level
   output logic [7:0]                data_bus_lines_in
);
   localparam remc_pkg::remc_level_t HI = remc_pkg::REMC_LVL_HIGH;
   localparam remc_pkg::remc_level_t SH = remc_pkg::REMC_LVL_SUPER;
   logic [7:0] ee [0:2047];
   logic [7:0] spare [0:255];
   logic       spare_on = 1'b0;
   logic       spare_rom = 1'b0;
   logic [5:0] spare_page = 6'h00;
   logic [7:0] last = 8'h00;
   logic [7:0] q;
   wire [13:0] a = byte_addr_lines;
   wire ce_l = chip_sel_lvl == remc_pkg::REMC_LVL_LOW;
   wire w_l = strobe_lvl == remc_pkg::REMC_LVL_LOW;
   wire hit = spare_on && a[13:8] == spare_page;
   wire drv = ce_l && out_en_lvl == remc_pkg::REMC_LVL_LOW;
   always_comb begin
      if (hit) q = spare[a[7:0]];
      else if (a <= 14'h07ff) q = ee[a[10:0]];
      else q = a[7:0] ^ 8'h5a;
   end
   // a released bus toggles so no stale byte can pass for data
   assign data_bus_lines_in = drv ? q
      : (data_bus_lines_oe ? data_bus_lines_out : ~last);
   initial foreach (ee[i]) ee[i] = 8'hff;
   always @(posedge clk_sys) begin
      last <= data_bus_lines_in;
      if (vpp_high && ce_l && out_en_lvl == HI && w_l) begin
         if (hit) spare[a[7:0]] <= spare[a[7:0]] & data_bus_lines_out;
         else if (a <= 14'h07ff)
            ee[a[10:0]] <= ee[a[10:0]] & data_bus_lines_out;
      end
      if (vpp_high && ce_l && out_en_lvl == SH && w_l) begin
         foreach (ee[i]) ee[i] <= 8'hff;
         if (spare_on && !spare_rom)
            foreach (spare[i]) spare[i] <= 8'hff;
      end
      if (vpp_high && chip_sel_lvl == SH && w_l && !spare_on) begin
         spare_on <= 1'b1;
         spare_page <= a[13:8];
         spare_rom <= a[13:8] >= 6'h08;
         foreach (spare[i]) spare[i] <= 8'hff;
      end
      if (vpp_high && chip_sel_lvl == SH && out_en_lvl == SH && w_l) begin
         foreach (spare[i]) spare[i] <= 8'hff;
      end
      if (vpp_high && chip_sel_lvl == HI && out_en_lvl == HI
          && strobe_lvl == SH) begin
         spare_on <= 1'b0;
         foreach (spare[i]) spare[i] <= 8'hff;
      end
   end
endmodule

/* bench/tb_top.sv */
// self-checking bench for the mode-pin controller
`timescale 1ns/10ps
module tb_top;
   logic clk_sys, srst, req_valid, req_ready, rsp_valid, rsp_match;
   logic rsp_in_rom, vpp_high, data_bus_lines_oe, got_rom, got_match;
   logic [13:0] req_addr, byte_addr_lines;
   logic [7:0] req_wdata, rsp_rdata, got;
   logic [7:0] data_bus_lines_in, data_bus_lines_out;
   remc_pkg::remc_op_t req_op;
   remc_pkg::remc_level_t chip_sel_lvl, out_en_lvl, strobe_lvl;
   int n_fail = 0;
   int cmp_count = 0;
   remc_ctrl #(.PROG_CYC(20), .ERASE_CYC(20), .REPL_CYC(30), .EREPL_CYC(20),
      .SETUP_CYC(3)) remc_ctrl_inst (.clk_sys(clk_sys), .srst(srst),
      .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
      .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_match(rsp_match), .rsp_in_rom(rsp_in_rom),
      .chip_sel_lvl(chip_sel_lvl), .out_en_lvl(out_en_lvl),
      .strobe_lvl(strobe_lvl), .vpp_high(vpp_high),
      .byte_addr_lines(byte_addr_lines),
      .data_bus_lines_in(data_bus_lines_in),
      .data_bus_lines_out(data_bus_lines_out),
      .data_bus_lines_oe(data_bus_lines_oe));
   remc_dev_model remc_dev_model_inst (.clk_sys(clk_sys),
      .chip_sel_lvl(chip_sel_lvl), .out_en_lvl(out_en_lvl),
      .strobe_lvl(strobe_lvl), .vpp_high(vpp_high),
      .byte_addr_lines(byte_addr_lines),
      .data_bus_lines_out(data_bus_lines_out),
      .data_bus_lines_oe(data_bus_lines_oe),
      .data_bus_lines_in(data_bus_lines_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(logic [7:0] g, logic [7:0] e, string m);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // one request, held until taken, then wait for its answer
   task automatic op(remc_pkg::remc_op_t o, logic [13:0] a, logic [7:0] d);
      int n;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_op <= o;
      req_addr <= a;
      req_wdata <= d;
      @(negedge clk_sys);
      while (req_ready !== 1'b1) @(negedge clk_sys);
      @(posedge clk_sys);
      req_valid <= 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      chk({7'h0, rsp_valid}, 8'h01, "no answer");
      got = rsp_rdata;
      got_rom = rsp_in_rom;
      got_match = rsp_match;
      @(posedge clk_sys);
   endtask
   task automatic t_read();
      op(remc_pkg::REMC_OP_READ, 14'h0800, 8'h00);
      chk(got, 8'h5a, "rom byte");
      chk({7'h0, got_rom}, 8'h01, "rom region");
      op(remc_pkg::REMC_OP_READ, 14'h07ff, 8'h00);
      chk(got, 8'hff, "eeprom byte");
      chk({7'h0, got_rom}, 8'h00, "eeprom region");
      $display("test read done");
   endtask
   task automatic t_prog_erase();
      op(remc_pkg::REMC_OP_PROGRAM, 14'h0123, 8'ha5);
      op(remc_pkg::REMC_OP_VERIFY, 14'h0123, 8'ha5);
      chk(got, 8'ha5, "verify byte");
      chk({7'h0, got_match}, 8'h01, "verify match");
      op(remc_pkg::REMC_OP_PROGRAM, 14'h0123, 8'h0f);
      op(remc_pkg::REMC_OP_READ, 14'h0123, 8'h00);
      chk(got, 8'h05, "zeros only");
      op(remc_pkg::REMC_OP_ERASE, 14'h0123, 8'h00);
      op(remc_pkg::REMC_OP_VERIFY, 14'h0123, 8'h00);
      chk(got, 8'hff, "erased byte");
      chk({7'h0, got_match}, 8'h01, "erase match");
      $display("test program erase done");
   endtask
   task automatic t_repl(logic [13:0] pg, logic [7:0] after_erase, string m);
      op(remc_pkg::REMC_OP_REPLACE, pg, 8'h00);
      op(remc_pkg::REMC_OP_READ, pg | 14'h0010, 8'h00);
      chk(got, 8'hff, "spare erased");
      op(remc_pkg::REMC_OP_PROGRAM, pg | 14'h0010, 8'h3c);
      op(remc_pkg::REMC_OP_READ, pg | 14'h0010, 8'h00);
      chk(got, 8'h3c, "spare loaded");
      op(remc_pkg::REMC_OP_ERASE, 14'h0000, 8'h00);
      op(remc_pkg::REMC_OP_READ, pg | 14'h0010, 8'h00);
      chk(got, after_erase, m);
      op(remc_pkg::REMC_OP_ERASE_REPL, 14'h0000, 8'h00);
      op(remc_pkg::REMC_OP_READ, 14'h2a10, 8'h00);
      chk(got, 8'h4a, "page restored");
      $display("test replace %s done", m);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      summarize();
   end
   initial begin
      srst = 1'b1;
      req_valid = 1'b0;
      req_op = remc_pkg::REMC_OP_READ;
      req_addr = 14'h0000;
      req_wdata = 8'h00;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      t_read();
      t_prog_erase();
      t_repl(14'h2a00, 8'h3c, "rom");
      t_repl(14'h0300, 8'hff, "eeprom");
      summarize();
   end
endmodule

/* rtl/remc_ctrl.sv */
// host controller that sequences the rom/eeprom mode pins
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - erase: ce low, oe super, vpp, 10ms strobe
// - verify: ce, oe low, vpp, strobe high
// - verify read may follow program or erase
// - replace: ce super, page address, 100ms strobe
// - load spare page by ordinary byte programs
// - erase-of-replace: ce, oe high, strobe super 10ms
// - never drive ce, oe super with strobe low
// - program: ce low, oe high, vpp, 10ms strobe
module remc_ctrl #(
   parameter int unsigned PROG_CYC  = remc_pkg::REMC_PROG_CYC,
   parameter int unsigned ERASE_CYC = remc_pkg::REMC_ERASE_CYC,
   parameter int unsigned REPL_CYC  = remc_pkg::REMC_REPL_CYC,
   parameter int unsigned EREPL_CYC = remc_pkg::REMC_EREPL_CYC,
   parameter int unsigned SETUP_CYC = remc_pkg::REMC_SETUP_CYC
) (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   // user request
   input  wire logic                  req_valid,
   output logic                       req_ready,
   input  wire remc_pkg::remc_op_t    req_op,
   input  wire logic [13:0]           req_addr,
   input  wire logic [7:0]            req_wdata,
   // user answer
   output logic                       rsp_valid,
   output logic [7:0]                 rsp_rdata,
   output logic                       rsp_match,
   output logic                       rsp_in_rom,
   // device pins
   output remc_pkg::remc_level_t      chip_sel_lvl,
   output remc_pkg::remc_level_t      out_en_lvl,
   output remc_pkg::remc_level_t      strobe_lvl,
   output logic                       vpp_high,
   output logic [13:0]                byte_addr_lines,
   input  wire logic [7:0]            data_bus_lines_in,
   output logic [7:0]                 data_bus_lines_out,
   output logic                       data_bus_lines_oe
);
   localparam int unsigned CNT_W = 32;

   initial begin
      if (PROG_CYC < 1 || ERASE_CYC < 1 || REPL_CYC < 1 || EREPL_CYC < 1 ||
          SETUP_CYC < 1)
         $error("remc_ctrl: cycle counts must be at least 1");
   end

   typedef enum logic [2:0] {
      REMC_ST_IDLE,
      REMC_ST_SETUP,
      REMC_ST_PULSE,
      REMC_ST_HOLD,
      REMC_ST_READ,
      REMC_ST_DONE
   } remc_state_t;

   remc_state_t        state;
   remc_state_t        next_state;
   remc_pkg::remc_op_t op;
   logic [13:0]        addr;
   logic [7:0]         wdata;
   logic [CNT_W-1:0]   cnt;
   logic [7:0]         bus_sync;
   logic [CNT_W-1:0]   next_cnt;
   logic               erased_last;

   ///////////////////////////////////////////////////////////////////////////
   // pin synchroniser for the returning data bus
   remc_sync #(.WIDTH(8)) u_data_sync (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .async_in (data_bus_lines_in),
      .sync_out (bus_sync)
   );

   ///////////////////////////////////////////////////////////////////////////
   // decode
   wire is_read   = (op == remc_pkg::REMC_OP_READ);
   wire is_prog   = (op == remc_pkg::REMC_OP_PROGRAM);
   wire is_erase  = (op == remc_pkg::REMC_OP_ERASE);
   wire is_verify = (op == remc_pkg::REMC_OP_VERIFY);
   wire is_repl   = (op == remc_pkg::REMC_OP_REPLACE);
   wire is_erepl  = (op == remc_pkg::REMC_OP_ERASE_REPL);
   wire is_rd     = is_read | is_verify;
   wire is_pulsed = is_prog | is_erase | is_repl | is_erepl;
   wire active    = (state != REMC_ST_IDLE) && (state != REMC_ST_DONE);
   wire in_pulse  = (state == REMC_ST_PULSE);

   // pulse length per operation, counted from the system clock
   wire [CNT_W-1:0] pulse_len =
      is_prog  ? CNT_W'(PROG_CYC)  :
      is_erase ? CNT_W'(ERASE_CYC) :
      is_repl  ? CNT_W'(REPL_CYC)  :
                 CNT_W'(EREPL_CYC);
   wire [CNT_W-1:0] read_len = CNT_W'(remc_pkg::REMC_READ_CYC);
   wire cnt_done = (cnt == '0);

   // replace uses only the page part of the address
   wire [13:0] drive_addr = is_repl ? {addr[13:8], remc_pkg::REMC_PAGE_LSB}
                                    : addr;

   ///////////////////////////////////////////////////////////////////////////
   // pin levels: ce and oe are never both super, so the strobe-low
   // spare-erase combination cannot be produced
   assign chip_sel_lvl = !active  ? remc_pkg::REMC_LVL_HIGH :
                         is_repl  ? remc_pkg::REMC_LVL_SUPER :
                         is_erepl ? remc_pkg::REMC_LVL_HIGH :
                                    remc_pkg::REMC_LVL_LOW;
   assign out_en_lvl   = !active  ? remc_pkg::REMC_LVL_HIGH :
                         is_erase ? remc_pkg::REMC_LVL_SUPER :
                         is_rd    ? remc_pkg::REMC_LVL_LOW :
                                    remc_pkg::REMC_LVL_HIGH;
   // strobe held high outside pulse; super only for erase-of-replace
   assign strobe_lvl   = !in_pulse ? remc_pkg::REMC_LVL_HIGH :
                         is_erepl  ? remc_pkg::REMC_LVL_SUPER :
                                     remc_pkg::REMC_LVL_LOW;
   assign vpp_high     = active & ~is_read;
   assign byte_addr_lines    = active ? drive_addr : 14'h0000;
   assign data_bus_lines_out = wdata;
   // drive only while programming and oe is high: no bus fight
   assign data_bus_lines_oe  = active & is_prog;
   assign req_ready          = (state == REMC_ST_IDLE);

   ///////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      next_state = state;
      case (state)
         REMC_ST_IDLE:  if (req_valid) next_state = REMC_ST_SETUP;
         REMC_ST_SETUP: if (cnt_done)
                           next_state = is_pulsed ? REMC_ST_PULSE
                                                  : REMC_ST_READ;
         REMC_ST_PULSE: if (cnt_done) next_state = REMC_ST_HOLD;
         REMC_ST_HOLD:  if (cnt_done) next_state = REMC_ST_DONE;
         REMC_ST_READ:  if (cnt_done) next_state = REMC_ST_DONE;
         REMC_ST_DONE:  next_state = REMC_ST_IDLE;
         default:       next_state = REMC_ST_IDLE;
      endcase
   end

   // counter reload points: setup span, pulse, then the same span of hold
   // so that address, data and supply bracket the strobe on both sides
   wire take      = (state == REMC_ST_IDLE) && req_valid;
   wire setup_end = (state == REMC_ST_SETUP) && cnt_done;
   wire pulse_end = in_pulse && cnt_done;

   always_comb begin
      next_cnt = cnt;
      if (take) begin
         next_cnt = CNT_W'(SETUP_CYC - 1);
      end else if (!cnt_done) begin
         next_cnt = cnt - 1'b1;
      end else if (setup_end) begin
         // read wait is not trimmed: one cycle of margin for the filter
         next_cnt = is_pulsed ? pulse_len - 1'b1 : read_len;
      end else if (pulse_end) begin
         next_cnt = CNT_W'(SETUP_CYC - 1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= REMC_ST_IDLE;
         op    <= remc_pkg::REMC_OP_READ;
         addr  <= 14'h0000;
         wdata <= 8'h00;
         cnt   <= '0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         // request latched once; pins stay fixed to the end
         if (take) begin
            op    <= req_op;
            addr  <= req_addr;
            wdata <= req_wdata;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // answer; a verify right after a bulk erase expects all ones
   wire       done_pulsed = (state == REMC_ST_DONE) && is_pulsed;
   wire [7:0] expect_byte = (is_verify && erased_last) ? remc_pkg::REMC_ERASED
                                                      : wdata;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rsp_valid  <= 1'b0;
         rsp_rdata  <= 8'h00;
         rsp_match  <= 1'b0;
         rsp_in_rom <= 1'b0;
         erased_last <= 1'b0;
      end else begin
         rsp_valid <= (next_state == REMC_ST_DONE) &&
                      (state != REMC_ST_DONE);
         if (state == REMC_ST_READ && cnt_done) begin
            rsp_rdata <= bus_sync;
            rsp_match <= (bus_sync == expect_byte);
         end
         if (state == REMC_ST_SETUP)
            rsp_in_rom <= (addr > remc_pkg::REMC_EE_LAST);
         // only the last pulsed operation decides; reads leave it alone
         if (done_pulsed)
            erased_last <= is_erase;
      end
   end
endmodule

/* rtl/remc_pkg.sv */
// shared constants for the rom/eeprom mode controller
package remc_pkg;
   // pin levels for the three-level control pins
   typedef enum logic [1:0] {
      REMC_LVL_LOW,
      REMC_LVL_HIGH,
      REMC_LVL_SUPER
   } remc_level_t;

   // operations the user side may request
   typedef enum logic [2:0] {
      REMC_OP_READ,
      REMC_OP_PROGRAM,
      REMC_OP_ERASE,
      REMC_OP_VERIFY,
      REMC_OP_REPLACE,
      REMC_OP_ERASE_REPL
   } remc_op_t;

   localparam int unsigned REMC_CLK_MHZ        = 125;
   localparam int unsigned REMC_PROG_PULSE_MS  = 10;
   localparam int unsigned REMC_ERASE_PULSE_MS = 10;
   localparam int unsigned REMC_REPL_PULSE_MS  = 100;
   localparam int unsigned REMC_EREPL_PULSE_MS = 10;
   localparam int unsigned REMC_SETUP_US       = 2;
   localparam int unsigned REMC_READ_NS        = 250;

   localparam int unsigned REMC_PROG_CYC  =
      REMC_PROG_PULSE_MS * 1000 * REMC_CLK_MHZ;
   localparam int unsigned REMC_ERASE_CYC =
      REMC_ERASE_PULSE_MS * 1000 * REMC_CLK_MHZ;
   localparam int unsigned REMC_REPL_CYC  =
      REMC_REPL_PULSE_MS * 1000 * REMC_CLK_MHZ;
   localparam int unsigned REMC_EREPL_CYC =
      REMC_EREPL_PULSE_MS * 1000 * REMC_CLK_MHZ;
   localparam int unsigned REMC_SETUP_CYC = REMC_SETUP_US * REMC_CLK_MHZ;
   // round up: 250 ns at 8 ns per cycle
   localparam int unsigned REMC_READ_CYC  =
      (REMC_READ_NS * REMC_CLK_MHZ + 999) / 1000;

   localparam int unsigned REMC_ADDR_W    = 14;
   localparam int unsigned REMC_DATA_W    = 8;
   localparam logic [13:0] REMC_EE_LAST   = 14'h07ff;
   localparam logic [7:0]  REMC_ERASED    = 8'hff;
   localparam logic [7:0]  REMC_PAGE_LSB  = 8'h00;
endpackage

/* rtl/remc_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module remc_sync #(
   parameter int unsigned WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             srst,
   // raw and filtered levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);

   initial begin
      if (WIDTH < 1) $error("remc_sync: WIDTH must be at least 1");
   end

   // a change counts only once the last two stages agree
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stage1   <= '0;
         stage2   <= '0;
         stage3   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         stage2   <= stage1;
         stage3   <= stage2;
         sync_out <= (agree & stage3) | (~agree & sync_out);
      end
   end
endmodule
